// ### sim/lor_router_tb.sv
// Self-checking bench for the logic output router, driven over APB.
// Assumes the step source model stands in for the step logic.
`timescale 1ns/1ps
module lor_router_tb;
   import lor_pkg::*;
   localparam int REFRESH_SIM = 16; // Short refresh period for simulation.
   logic mclk;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic taskUpdate;
   logic [NUM_STEP-1:0] stepDigital;
   logic [NUM_STEP-1:0][VAL_W-1:0] stepAnalog;
   logic [NUM_SEQ-1:0] seqFunc;
   logic [NUM_ANA-1:0][VAL_W-1:0] anaDest;
   logic [NUM_ANA-1:0] anaDestValid;
   logic [NUM_YTERM-1:0] yTerm;
   logic [VAL_W-1:0] monitorTerm;
   int failCount = 0; // Mismatches seen.
   int compares = 0; // Comparisons made.
   // Analog codes in slot order.
   logic [15:0] anaCode [NUM_ANA] = '{CODE_AUX1, CODE_AUX2, CODE_PIDCMD, CODE_PIDFB,
      CODE_RATIO, CODE_TRQA, CODE_TRQB, CODE_MON};
   lor_router #(.REFRESH_CYCLES(REFRESH_SIM)) u_lor_router (.mclk(mclk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .taskUpdate(taskUpdate),
      .stepDigital(stepDigital), .stepAnalog(stepAnalog), .seqFunc(seqFunc),
      .anaDest(anaDest), .anaDestValid(anaDestValid), .yTerm(yTerm),
      .monitorTerm(monitorTerm));
   lor_step_source u_lor_step_source (.mclk(mclk), .taskUpdate(taskUpdate),
      .stepDigital(stepDigital), .stepAnalog(stepAnalog));
   // ************************************************************
   // Clock and helpers
   // ************************************************************
   // A 40 ns clock.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Prints the verdict and ends the run.
   task automatic close_out();
      if (failCount == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Compares a seen value with the expected one.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, seen);
         failCount++;
      end
   endtask
   // Byte address of word idx plus i.
   function automatic logic [11:0] adr(input logic [5:0] idx, input int i);
      return {4'h0, idx + 6'(i), 2'b00};
   endfunction
   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failCount++;
         close_out();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Register write.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   // Register read with expected data and error flag.
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic err);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk("prdata", r, exp);
      chk("pslverr", {31'h0, e}, {31'h0, err});
   endtask
   // Ends a task cycle and lets its results land.
   task automatic cycle();
      u_lor_step_source.end_cycle();
      repeat (3) @(posedge mclk);
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      int n;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      // Reset values, and an unmapped word that must be refused.
      rdchk(adr(IDX_SRC, 0), {16'h0, SRC_RESET}, 1'b0);
      rdchk(adr(IDX_FUNC, 9), {16'h0, FUNC_RESET}, 1'b0);
      rdchk(12'h0A0, 32'h0, 1'b1);
      chk("seqReset", {22'h0, seqFunc}, 32'h0);
      // Every analog code, one channel each, plus the monitor terminal.
      for (int i = 0; i < NUM_ANA; i++) begin
         wr(adr(IDX_SRC, i), 32'(i + 1));
         wr(adr(IDX_FUNC, i), {16'h0, anaCode[i]});
         u_lor_step_source.set_ana(i + 1, 16'h1000 + 16'(i));
      end
      wr(adr(IDX_FMSEL, 0), 32'h8);
      cycle();
      for (int i = 0; i < NUM_ANA; i++) begin
         chk("anaDest", {16'h0, anaDest[i]}, 32'h1000 + 32'(i));
         chk("anaValid", {31'h0, anaDestValid[i]}, 32'h1);
      end
      chk("monitor", {16'h0, monitorTerm}, 32'h1007);
      // Out-of-range source (active-on code) and disabled source (active-off code) assert nothing.
      wr(adr(IDX_SRC, 0), 32'd201);
      wr(adr(IDX_FUNC, 0), {16'h0, CODE_ON_BASE});
      u_lor_step_source.set_dig(1, 1'b1);
      cycle();
      chk("srcRange", {22'h0, seqFunc}, 32'h0);
      chk("slotFree", {31'h0, anaDestValid[0]}, 32'h0);
      wr(adr(IDX_SRC, 0), 32'h0);
      wr(adr(IDX_FUNC, 0), 32'h0);
      cycle();
      chk("srcOff", {22'h0, seqFunc}, 32'h0);
      // Every sequence code in both senses through channel 1.
      wr(adr(IDX_SRC, 0), 32'h1);
      for (int k = 0; k < NUM_SEQ; k++) begin
         for (int on = 0; on < 2; on++) begin
            wr(adr(IDX_FUNC, 0), 32'(k) + (on != 0 ? 32'(CODE_ON_BASE) : 32'h0));
            u_lor_step_source.set_dig(1, on[0]);
            cycle();
            chk("seqFunc", {22'h0, seqFunc}, 32'h1 << k);
            rdchk(adr(IDX_CHAN, 0), 32'(on), 1'b0);
         end
      end
      // A result change without a strobe must not reach the channels.
      u_lor_step_source.set_dig(1, 1'b0);
      repeat (4) @(posedge mclk);
      chk("hold", {22'h0, seqFunc}, 32'h200);
      // A write to a read-only word changes nothing.
      wr(adr(IDX_SEQ, 0), 32'h0);
      rdchk(adr(IDX_SEQ, 0), 32'h200, 1'b0);
      // Terminal 1 follows channel 1 within one refresh period.
      // Channel 1 is held for many periods, as a stretching timer would do.
      wr(adr(IDX_YSEL, 0), 32'h1);
      n = 0;
      while (yTerm[0] !== 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      chk("yTerm", {31'h0, yTerm[0]}, 32'h1);
      chk("yUnused", {28'h0, yTerm[4:1]}, 32'h0);
      chk("yPeriod", 32'(n <= REFRESH_SIM + 2), 32'h1);
      close_out();
   end
endmodule // lor_router_tb

// ### sim/lor_step_source.sv
// Partner model: the step logic that feeds the router with results and task strobes.
// Assumes the bench calls its tasks from one process that runs on mclk.
`timescale 1ns/1ps
module lor_step_source
   import lor_pkg::*;
(
   input wire logic mclk, // System clock.
   output logic taskUpdate, // End of task cycle strobe.
   output logic [NUM_STEP-1:0] stepDigital, // Digital step results.
   output logic [NUM_STEP-1:0][VAL_W-1:0] stepAnalog // Analog step results.
);
   // Results start low, so that nothing is asserted before the first task cycle.
   initial begin
      taskUpdate = 1'b0;
      stepDigital = '0;
      stepAnalog = '0;
   end
   // Sets one digital result, which also stays readable by other steps.
   task automatic set_dig(input int n, input logic v);
      @(posedge mclk);
      stepDigital[n-1] <= v;
   endtask
   // Sets one analog result.
   task automatic set_ana(input int n, input logic [VAL_W-1:0] v);
      @(posedge mclk);
      stepAnalog[n-1] <= v;
   endtask
   // Closes a task cycle with a one-cycle strobe once all results have settled.
   task automatic end_cycle();
      @(posedge mclk);
      taskUpdate <= 1'b1;
      @(posedge mclk);
      taskUpdate <= 1'b0;
   endtask
endmodule // lor_step_source

// ### src/lor_pkg.sv
// Constants for the logic output router: register map, field sizes and timing.
// Assumes a 25 MHz mclk and a 32-bit APB slave port with 12 address bits.
package lor_pkg;
   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int NUM_CHAN = 10; // Output channels.
   localparam int NUM_STEP = 200; // Step results that a channel may select.
   localparam int NUM_SEQ = 10; // Sequence input functions, codes 0 to 9.
   localparam int NUM_ANA = 8; // Analog destinations.
   localparam int NUM_YTERM = 5; // General digital output terminals.
   localparam int VAL_W = 16; // Analog value and setting width.
   // ************************************************************
   // Register map, word index = paddr[7:2]
   // ************************************************************
   localparam logic [5:0] IDX_SRC = 6'h00; // Source selectors, channels 1 to 10.
   localparam logic [5:0] IDX_FUNC = 6'h10; // Function selectors, channels 1 to 10.
   localparam logic [5:0] IDX_YSEL = 6'h20; // Digital terminal channel selects.
   localparam logic [5:0] IDX_FMSEL = 6'h25; // Analog monitor terminal channel select.
   localparam logic [5:0] IDX_CHAN = 6'h26; // Channel states, read only.
   localparam logic [5:0] IDX_SEQ = 6'h27; // Sequence function states, read only.
   localparam logic [15:0] SRC_RESET = 16'h0000; // Source selector reset: disabled.
   localparam logic [15:0] FUNC_RESET = 16'h0064; // Function selector reset value.
   localparam logic [15:0] SRC_MAX = 16'h00C8; // Highest step number.
   // ************************************************************
   // Function codes
   // ************************************************************
   localparam logic [15:0] CODE_ON_BASE = 16'h03E8; // Active-on offset.
   localparam logic [15:0] CODE_SEQ_END = 16'h000A; // First code past the sequence set.
   localparam logic [15:0] CODE_AUX1 = 16'h1F41; // Auxiliary frequency command 1.
   localparam logic [15:0] CODE_AUX2 = 16'h1F42; // Auxiliary frequency command 2.
   localparam logic [15:0] CODE_PIDCMD = 16'h1F43; // PID process command.
   localparam logic [15:0] CODE_PIDFB = 16'h1F45; // PID feedback.
   localparam logic [15:0] CODE_RATIO = 16'h1F46; // Ratio setting.
   localparam logic [15:0] CODE_TRQA = 16'h1F47; // Torque limit A.
   localparam logic [15:0] CODE_TRQB = 16'h1F48; // Torque limit B.
   localparam logic [15:0] CODE_MON = 16'h1F54; // Analog monitor.
   localparam logic [3:0] ANA_NONE = 4'h8; // No analog slot.
   // ************************************************************
   // Timing
   // ************************************************************
   localparam longint CLK_HZ = 25000000; // mclk rate in Hz.
   localparam longint REFRESH_MS = 5; // Digital terminal refresh period in ms.
   localparam int REFRESH_CYC = int'(REFRESH_MS * CLK_HZ / 1000); // Refresh in cycles.
endpackage : lor_pkg

// ### src/lor_router.sv
// Logic output router: ten output channels of the step logic, with APB registers.
// Assumes step results and the task update strobe come from logic on mclk.
//
// Overview of operation
// R01: Channel selects step n; zero disables.
// R02: Step results leave only through channels.
// R03: Step results stay available to other steps.
// R04: Digital function codes match terminal input set.
// R05: Codes 0-9 active-off, plus 1000 active-on.
// R06: Analog codes 8001-8003, 8005-8008 and 8020 route to destinations.
// R07: Digital and monitor terminals show selected channels.
// R08: Digital terminals refresh every 5 ms.
// R09: Configurer adds delay timers before terminals.
// R10: All channels update together per task cycle.
// R11: Invalid source gives inactive, unasserted channel.
`timescale 1ns/1ps
module lor_router
   import lor_pkg::*;
#(
   parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
   input wire logic mclk, // System clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic taskUpdate, // End of task cycle, one-cycle pulse.
   input wire logic [NUM_STEP-1:0] stepDigital, // Digital step results.
   input wire logic [NUM_STEP-1:0][VAL_W-1:0] stepAnalog, // Analog step results.
   output logic [NUM_SEQ-1:0] seqFunc, // Sequence input functions.
   output logic [NUM_ANA-1:0][VAL_W-1:0] anaDest, // Analog destination values.
   output logic [NUM_ANA-1:0] anaDestValid, // Analog destination driven.
   output logic [NUM_YTERM-1:0] yTerm, // General digital output terminals.
   output logic [VAL_W-1:0] monitorTerm // Analog monitor terminal value.
);
   // ************************************************************
   // Helpers
   // ************************************************************
   // True when a source selector names a step.
   function automatic logic srcValid(input logic [15:0] sel);
      return (sel != 16'h0000) && (sel <= SRC_MAX);
   endfunction

   // Maps an analog function code onto its destination slot.
   function automatic logic [3:0] anaSlot(input logic [15:0] code);
      case (code)
         CODE_AUX1: return 4'h0;
         CODE_AUX2: return 4'h1;
         CODE_PIDCMD: return 4'h2;
         CODE_PIDFB: return 4'h3;
         CODE_RATIO: return 4'h4;
         CODE_TRQA: return 4'h5;
         CODE_TRQB: return 4'h6;
         CODE_MON: return 4'h7;
         default: return ANA_NONE;
      endcase
   endfunction

   // True when a terminal select names a channel, 1 to 10.
   function automatic logic chanSelValid(input logic [3:0] sel);
      return (sel != 4'h0) && (sel <= 4'hA);
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [NUM_CHAN-1:0][15:0] src; // Source selectors.
      logic [NUM_CHAN-1:0][15:0] func; // Function selectors.
      logic [NUM_YTERM-1:0][3:0] ySel; // Digital terminal channel selects.
      logic [3:0] fmSel; // Monitor terminal channel select.
      logic [NUM_CHAN-1:0] chanDig; // Channel digital states.
      logic [NUM_CHAN-1:0][VAL_W-1:0] chanAna; // Channel analog values.
      logic [NUM_SEQ-1:0] seq; // Registered sequence functions.
      logic [NUM_ANA-1:0][VAL_W-1:0] ana; // Registered analog destinations.
      logic [NUM_ANA-1:0] anaVld; // Registered destination valid flags.
      logic [NUM_YTERM-1:0] y; // Registered digital terminals.
      logic [VAL_W-1:0] fm; // Registered monitor terminal.
      logic [16:0] refCnt; // Refresh period counter.
      logic [31:0] rdata; // Read data, loaded in the setup phase.
   } lor_state_s;

   lor_state_s state_ff; // Registered state.
   lor_state_s nxt_state; // Next state.
   logic [5:0] regIdx; // Word index of the bus address.
   logic regMapped; // Address hits a register.
   logic refTick; // Last cycle of a refresh period.
   logic [7:0] stepIdx; // Step index during channel update.
   logic [3:0] slot; // Analog slot during decode.
   logic [15:0] code; // Function code during decode.
   logic [3:0] termIdx; // Channel index for a terminal.

   // ************************************************************
   // Bus decode
   // ************************************************************
   // Finds the word index and whether it names a register.
   always_comb begin
      regIdx = paddr[7:2];
      regMapped = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00) &&
         ((regIdx < IDX_SRC + 6'd10) ||
          (regIdx >= IDX_FUNC && regIdx < IDX_FUNC + 6'd10) ||
          (regIdx >= IDX_YSEL && regIdx <= IDX_SEQ));
   end

   // Zero wait states; an unmapped access ends with an error.
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~regMapped;

   assign refTick = (32'(state_ff.refCnt) == REFRESH_CYCLES - 1);

   // ************************************************************
   // Next state
   // ************************************************************
   // Register writes, read data, channel update and output decode.
   always_comb begin
      nxt_state = state_ff;
      stepIdx = 8'h00;
      slot = ANA_NONE;
      code = 16'h0000;
      termIdx = 4'h0;
      // Read data is fetched in the setup phase so it stands in the access phase.
      if (psel && !penable) begin
         nxt_state.rdata = 32'h0000_0000;
         if (regIdx < IDX_SRC + 6'd10) begin
            nxt_state.rdata[15:0] = state_ff.src[regIdx[3:0]];
         end else if (regIdx >= IDX_FUNC && regIdx < IDX_FUNC + 6'd10) begin
            nxt_state.rdata[15:0] = state_ff.func[regIdx[3:0]];
         end else if (regIdx >= IDX_YSEL && regIdx < IDX_FMSEL) begin
            nxt_state.rdata[3:0] = state_ff.ySel[3'(regIdx - IDX_YSEL)];
         end else if (regIdx == IDX_FMSEL) begin
            nxt_state.rdata[3:0] = state_ff.fmSel;
         end else if (regIdx == IDX_CHAN) begin
            nxt_state.rdata[9:0] = state_ff.chanDig;
         end else if (regIdx == IDX_SEQ) begin
            nxt_state.rdata[9:0] = state_ff.seq;
         end
      end
      // Writes take effect at the access edge; read-only words ignore them.
      if (psel && penable && pwrite && regMapped) begin
         if (regIdx < IDX_SRC + 6'd10) begin
            nxt_state.src[regIdx[3:0]] = pwdata[15:0];
         end else if (regIdx >= IDX_FUNC && regIdx < IDX_FUNC + 6'd10) begin
            nxt_state.func[regIdx[3:0]] = pwdata[15:0];
         end else if (regIdx >= IDX_YSEL && regIdx < IDX_FMSEL) begin
            nxt_state.ySel[3'(regIdx - IDX_YSEL)] = pwdata[3:0];
         end else if (regIdx == IDX_FMSEL) begin
            nxt_state.fmSel = pwdata[3:0];
         end
      end
      // All channels load together at the end of a task cycle.
      if (taskUpdate) begin // R10
         for (int i = 0; i < NUM_CHAN; i++) begin
            if (srcValid(state_ff.src[i])) begin
               stepIdx = state_ff.src[i][7:0] - 8'h01;
               nxt_state.chanDig[i] = stepDigital[stepIdx]; // R01
               nxt_state.chanAna[i] = stepAnalog[stepIdx]; // R01
            end else begin
               nxt_state.chanDig[i] = 1'b0; // R11
               nxt_state.chanAna[i] = '0; // R11
            end
         end
      end
      // Functions see step results only by way of the channels.
      nxt_state.seq = '0; // R02
      nxt_state.ana = '0;
      nxt_state.anaVld = '0;
      // Highest channel first, so the lowest channel wins an analog slot.
      for (int i = NUM_CHAN - 1; i >= 0; i--) begin
         code = state_ff.func[i];
         if (srcValid(state_ff.src[i])) begin // R11
            if (code < CODE_SEQ_END) begin
               nxt_state.seq[code[3:0]] = nxt_state.seq[code[3:0]] |
                  ~state_ff.chanDig[i]; // R04 R05
            end else if (code >= CODE_ON_BASE && code < CODE_ON_BASE + CODE_SEQ_END) begin
               slot = 4'(code - CODE_ON_BASE);
               nxt_state.seq[slot] = nxt_state.seq[slot] | state_ff.chanDig[i]; // R05
            end else begin
               slot = anaSlot(code);
               if (slot != ANA_NONE) begin
                  nxt_state.ana[slot[2:0]] = state_ff.chanAna[i]; // R06
                  nxt_state.anaVld[slot[2:0]] = 1'b1; // R06
               end
            end
         end
      end
      // Digital terminals sample the channels once per refresh period.
      nxt_state.refCnt = refTick ? 17'h00000 : state_ff.refCnt + 17'h00001;
      if (refTick) begin // R08
         for (int k = 0; k < NUM_YTERM; k++) begin
            termIdx = state_ff.ySel[k] - 4'h1;
            nxt_state.y[k] = chanSelValid(state_ff.ySel[k]) &
               state_ff.chanDig[termIdx]; // R07
         end
      end
      // Monitor terminal follows its channel every cycle.
      termIdx = state_ff.fmSel - 4'h1;
      nxt_state.fm = chanSelValid(state_ff.fmSel) ? state_ff.chanAna[termIdx] : '0; // R07
   end

   // ************************************************************
   // Registers
   // ************************************************************
   // Holds all state; reset sets every selector to its default.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_ff <= '0;
         for (int i = 0; i < NUM_CHAN; i++) begin
            state_ff.src[i] <= SRC_RESET;
            state_ff.func[i] <= FUNC_RESET;
         end
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs come straight from the state registers.
   assign prdata = state_ff.rdata;
   assign seqFunc = state_ff.seq;
   assign anaDest = state_ff.ana;
   assign anaDestValid = state_ff.anaVld;
   assign yTerm = state_ff.y;
   assign monitorTerm = state_ff.fm;

   // Step results are also free for other steps to use directly; nothing here gates them.
   // R03

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   logic anySrc; // Some channel names a valid step.
   // Collects whether any channel could carry a step result out of the logic.
   always_comb begin
      anySrc = 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) begin
         anySrc = anySrc | srcValid(state_ff.src[i]);
      end
   end

   logic [7:0] pickIdx0; // Step index named by channel 1.
   logic pick0; // Step result channel 1 would load.
   assign pickIdx0 = state_ff.src[0][7:0] - 8'h01;
   assign pick0 = stepDigital[pickIdx0];

   sequence sq_setup;
      psel && !penable && !pwrite && regIdx == IDX_CHAN && regMapped;
   endsequence
   sequence sq_access;
      psel && penable && pready;
   endsequence

   AST_DISABLED: assert property (taskUpdate && state_ff.src[0] == 16'h0000 |=> // R11
      !state_ff.chanDig[0]) else $error("Disabled channel not cleared.");
   AST_SELECT: assert property (taskUpdate && srcValid(state_ff.src[0]) |=> // R01
      state_ff.chanDig[0] == $past(pick0)) else $error("Channel missed its step.");
   AST_HOLD: assert property (!taskUpdate |=> $stable(state_ff.chanDig) && // R10
      $stable(state_ff.chanAna)) else $error("Channel changed between task cycles.");
   AST_ACT_ON: assert property (srcValid(state_ff.src[0]) && state_ff.func[0] == 16'h03EF // R05
      && state_ff.chanDig[0] |=> seqFunc[7]) else $error("Active-on function not set.");
   AST_ACT_OFF: assert property (srcValid(state_ff.src[0]) && state_ff.func[0] == 16'h0007 // R05
      && !state_ff.chanDig[0] |=> seqFunc[7]) else $error("Active-off function not set.");
   AST_ANALOG: assert property (srcValid(state_ff.src[0]) && state_ff.func[0] == CODE_MON // R06
      |=> anaDestValid[7] && anaDest[7] == $past(state_ff.chanAna[0]))
      else $error("Analog route wrong.");
   AST_Y_STABLE: assert property (!refTick |=> $stable(yTerm)) // R08
      else $error("Terminal changed outside refresh.");
   AST_Y_VALUE: assert property (refTick && state_ff.ySel[0] == 4'h1 |=> // R07
      yTerm[0] == $past(state_ff.chanDig[0])) else $error("Terminal missed its channel.");
   AST_READ_CHAN: assert property (sq_setup ##1 sq_access |-> // R07
      prdata[9:0] == $past(state_ff.chanDig)) else $error("Channel read wrong.");
   AST_NO_ROUTE: assert property (!anySrc |=> // R02
      seqFunc == '0 && anaDestValid == '0) else $error("Function driven with no channel.");

endmodule : lor_router
